// File: core/dsr_pkg.sv
// Package for the device status readback block.
// Assumes a single 40 MHz core clock and a plain register port.
package dsr_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] DSR_ADDR_STATE = 8'h08;
  localparam logic [7:0] DSR_ADDR_INT_STATUS = 8'h0C;
  localparam logic [7:0] DSR_ADDR_INT_MASK = 8'h10;
  localparam logic [7:0] DSR_ADDR_MODE_CTRL = 8'h14;
  // ------------------------------------------------------------
  // Field positions of the readback word
  // ------------------------------------------------------------
  localparam int DSR_BIT_DUPLEX = 0;
  localparam int DSR_BIT_LINK = 1;
  localparam int DSR_BIT_PORT_LO = 2;
  localparam int DSR_BIT_PAUSED = 4;
  localparam int DSR_BIT_SERDES = 5;
  localparam int DSR_BIT_SPEED_LO = 6;
  // ------------------------------------------------------------
  // Interrupt events and mode control fields
  // ------------------------------------------------------------
  localparam int DSR_EV_LINK_CHANGE = 0;
  localparam int DSR_EV_PAUSE_CHANGE = 1;
  localparam int DSR_EV_SPEED_SET = 2;
  localparam int DSR_EV_COUNT = 3;
  localparam int DSR_CTRL_FORCE_LINK = 0;
  localparam int DSR_CTRL_FORCE_SPEED = 1;
  localparam int DSR_CTRL_AUTO_SPEED = 2;
  localparam int DSR_CTRL_SPEED_LO = 3;
  localparam int DSR_CTRL_FORCE_DUPLEX = 5;
  localparam int DSR_CTRL_DUPLEX_VAL = 6;
  localparam int DSR_CTRL_WIDTH = 7;
  localparam logic [DSR_CTRL_WIDTH-1:0] DSR_CTRL_RESET = 7'h00;
  // ------------------------------------------------------------
  // Speed and port encodings
  // ------------------------------------------------------------
  localparam logic [1:0] DSR_SPEED_10 = 2'h0;
  localparam logic [1:0] DSR_SPEED_100 = 2'h1;
  localparam logic [1:0] DSR_SPEED_1000 = 2'h2;
  localparam logic [1:0] DSR_PORT_FIRST = 2'h0;
  localparam logic [1:0] DSR_PORT_SECOND = 2'h1;
endpackage : dsr_pkg

// File: core/dsr_pause_if.sv
// Interface carrying pause events between the top and the pause tracker.
// Assumes events are single-cycle pulses in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
interface dsr_pause_if;
  logic xoff_rx;
  logic xon_rx;
  logic timer_expired;
  logic flow_enable;
  logic paused;
  modport tracker (input xoff_rx, input xon_rx, input timer_expired,
    input flow_enable, output paused);
  modport top (output xoff_rx, output xon_rx, output timer_expired,
    output flow_enable, input paused);
endinterface : dsr_pause_if
`default_nettype wire

// File: core/dsr_pause_track.sv
// Transmit pause tracker for the device status readback.
// Assumes pause events are single-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module dsr_pause_track (
  input wire logic clk,
  input wire logic rst,
  dsr_pause_if.tracker pif
);
  logic paused_reg;

  // Clearing events beat a same-cycle pause request: the timer or
  // XON ends the pause, whichever comes first.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      paused_reg <= 1'b0;
    end
    else if (!pif.flow_enable)
    begin
      paused_reg <= 1'b0;
    end
    else if (pif.timer_expired || pif.xon_rx)
    begin
      paused_reg <= 1'b0;
    end
    else if (pif.xoff_rx)
    begin
      paused_reg <= 1'b1;
    end
  end

  assign pif.paused = paused_reg;
endmodule : dsr_pause_track
`default_nettype wire

// File: core/dsr_status.sv
// Device status readback register bank with interrupt status and mask.
// Assumes a plain register port: one-cycle strobes, read data next cycle.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Duplex indicator at bit 0: 0 half, 1 full duplex.
// - Duplex comes from auto-negotiation result or software forced value.
// - Link-up flag at bit 1: 1 when a link is configured.
// - Without internal serializer, link-up is valid only with force-link set.
// - Serializer: negotiated link with autoneg, else mirrors force-link bit.
// - Internal PHY mode: link-up follows internal link signal.
// - Port identifier in bits 3:2: 00 first port, 01 second port.
// - Transmit-paused bit 4 sets on XOFF with symmetric flow control in full duplex.
// - Transmit-paused clears on pause timer expiry or XON, first wins.
// - Speed codes: 00 10M, 01 100M, 10/11 1000M; invalid in serializer.
// - Auto-speed configures speed only once after internal link asserts or auto-speed is set.
module dsr_status #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic second_port,
  input wire logic has_serializer,
  input wire logic interface_mode_select,
  input wire logic autoneg_enable,
  input wire logic autoneg_link_ok,
  input wire logic autoneg_full_duplex,
  input wire logic phy_link,
  input wire logic [1:0] phy_speed,
  input wire logic [1:0] detected_speed,
  input wire logic xoff_rx,
  input wire logic xon_rx,
  input wire logic pause_timer_expired,
  input wire logic symmetric_flow_enable
);
  // Only the low byte is decoded, so a narrower bus cannot be served
  if (ADDR_WIDTH < 8)
  begin : g_addr_width_check
    $error("dsr_status: ADDR_WIDTH must be at least 8");
  end

  // ------------------------------------------------------------
  // Mode control register and interrupt registers
  // ------------------------------------------------------------
  logic [dsr_pkg::DSR_CTRL_WIDTH-1:0] ctrl_reg;
  logic [dsr_pkg::DSR_EV_COUNT-1:0] int_status_reg;
  logic [dsr_pkg::DSR_EV_COUNT-1:0] int_mask_reg;
  logic [dsr_pkg::DSR_EV_COUNT-1:0] events;
  logic [31:0] rdata_reg;
  logic [31:0] state_word;
  logic [7:0] a8;
  logic force_link;
  logic force_speed;
  logic auto_speed;
  logic serdes;
  logic duplex;
  logic link_up;
  logic link_prev_reg;
  logic paused_prev_reg;
  logic [1:0] auto_speed_reg;
  logic auto_speed_done_reg;
  logic [1:0] speed;
  logic speed_set_pulse;

  assign a8 = addr[7:0];
  assign force_link = ctrl_reg[dsr_pkg::DSR_CTRL_FORCE_LINK];
  assign force_speed = ctrl_reg[dsr_pkg::DSR_CTRL_FORCE_SPEED];
  assign auto_speed = ctrl_reg[dsr_pkg::DSR_CTRL_AUTO_SPEED];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= dsr_pkg::DSR_CTRL_RESET;
    end
    else if (wr_en && a8 == dsr_pkg::DSR_ADDR_MODE_CTRL)
    begin
      ctrl_reg <= wdata[dsr_pkg::DSR_CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      int_mask_reg <= '0;
    end
    else if (wr_en && a8 == dsr_pkg::DSR_ADDR_INT_MASK)
    begin
      int_mask_reg <= wdata[dsr_pkg::DSR_EV_COUNT-1:0];
    end
  end

  // ------------------------------------------------------------
  // Status derivation
  // ------------------------------------------------------------
  assign serdes = interface_mode_select;

  always_comb
  begin
    if (ctrl_reg[dsr_pkg::DSR_CTRL_FORCE_DUPLEX])
    begin
      duplex = ctrl_reg[dsr_pkg::DSR_CTRL_DUPLEX_VAL];
    end
    else
    begin
      duplex = autoneg_full_duplex;
    end
  end

  always_comb
  begin
    if (!has_serializer)
    begin
      link_up = force_link && phy_link;
    end
    else if (serdes)
    begin
      link_up = autoneg_enable ? autoneg_link_ok : force_link;
    end
    else
    begin
      link_up = phy_link;
    end
  end

  // Auto-speed result is latched once per link-up; later changes of
  // the detector are ignored until the internal link drops or auto-speed is cleared.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      auto_speed_reg <= dsr_pkg::DSR_SPEED_10;
      auto_speed_done_reg <= 1'b0;
    end
    else if (!phy_link || !auto_speed)
    begin
      auto_speed_done_reg <= 1'b0;
    end
    else if (!auto_speed_done_reg)
    begin
      auto_speed_reg <= detected_speed;
      auto_speed_done_reg <= 1'b1;
    end
  end

  assign speed_set_pulse = auto_speed && phy_link && !auto_speed_done_reg;

  always_comb
  begin
    if (force_speed)
    begin
      speed = ctrl_reg[dsr_pkg::DSR_CTRL_SPEED_LO +: 2];
    end
    else if (auto_speed)
    begin
      speed = auto_speed_reg;
    end
    else
    begin
      speed = phy_speed;
    end
  end

  // ------------------------------------------------------------
  // Pause tracking
  // ------------------------------------------------------------
  dsr_pause_if pif ();
  assign pif.xoff_rx = xoff_rx && symmetric_flow_enable;
  assign pif.xon_rx = xon_rx;
  assign pif.timer_expired = pause_timer_expired;
  assign pif.flow_enable = symmetric_flow_enable && duplex;

  dsr_pause_track u_pause (
    .clk(clk),
    .rst(rst),
    .pif(pif.tracker)
  );

  // ------------------------------------------------------------
  // Readback word
  // ------------------------------------------------------------
  always_comb
  begin
    state_word = '0;
    state_word[dsr_pkg::DSR_BIT_DUPLEX] = duplex;
    state_word[dsr_pkg::DSR_BIT_LINK] = link_up;
    state_word[dsr_pkg::DSR_BIT_PORT_LO +: 2] = second_port ?
      dsr_pkg::DSR_PORT_SECOND : dsr_pkg::DSR_PORT_FIRST;
    state_word[dsr_pkg::DSR_BIT_PAUSED] = pif.paused;
    state_word[dsr_pkg::DSR_BIT_SERDES] = serdes;
    state_word[dsr_pkg::DSR_BIT_SPEED_LO +: 2] = speed;
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link_prev_reg <= 1'b0;
      paused_prev_reg <= 1'b0;
    end
    else
    begin
      link_prev_reg <= link_up;
      paused_prev_reg <= pif.paused;
    end
  end

  always_comb
  begin
    events = '0;
    events[dsr_pkg::DSR_EV_LINK_CHANGE] = link_up ^ link_prev_reg;
    events[dsr_pkg::DSR_EV_PAUSE_CHANGE] = pif.paused ^ paused_prev_reg;
    events[dsr_pkg::DSR_EV_SPEED_SET] = speed_set_pulse;
  end

  // A new event wins over a same-cycle write-one-to-clear.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      int_status_reg <= '0;
    end
    else if (wr_en && a8 == dsr_pkg::DSR_ADDR_INT_STATUS)
    begin
      int_status_reg <= (int_status_reg &
        ~wdata[dsr_pkg::DSR_EV_COUNT-1:0]) | events;
    end
    else
    begin
      int_status_reg <= int_status_reg | events;
    end
  end

  assign irq = |(int_status_reg & int_mask_reg);

  // ------------------------------------------------------------
  // Read port; the readback word has no write decode at all
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg <= '0;
    end
    else if (rd_en)
    begin
      unique case (a8)
        dsr_pkg::DSR_ADDR_STATE: rdata_reg <= state_word;
        dsr_pkg::DSR_ADDR_INT_STATUS:
          rdata_reg <= {29'h0000000, int_status_reg};
        dsr_pkg::DSR_ADDR_INT_MASK:
          rdata_reg <= {29'h0000000, int_mask_reg};
        dsr_pkg::DSR_ADDR_MODE_CTRL: rdata_reg <= {25'h0000000, ctrl_reg};
        default: rdata_reg <= '0;
      endcase
    end
    else
    begin
      rdata_reg <= '0;
    end
  end

  assign rdata = rdata_reg;
endmodule : dsr_status
`default_nettype wire

// File: verification/dsr_status_properties.sv
// Port-level checks for the device status readback block.
// Assumes one core clock and async active-high reset on rst.
`timescale 1ns/1ps
`default_nettype none
module dsr_status_properties #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic irq,
  input wire logic second_port,
  input wire logic has_serializer,
  input wire logic interface_mode_select,
  input wire logic autoneg_enable,
  input wire logic autoneg_link_ok,
  input wire logic phy_link,
  input wire logic xon_rx,
  input wire logic pause_timer_expired
);
  // ----
  // Shadow of mode control, since forced fields are not visible at ports
  // ----
  logic [6:0] ctrl_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl_reg <= 7'h00;
    else if (wr_en && addr[7:0] == dsr_pkg::DSR_ADDR_MODE_CTRL)
      ctrl_reg <= wdata[6:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd;
    rd_en && addr[7:0] == dsr_pkg::DSR_ADDR_STATE;
  endsequence
  sequence s_clr;
    xon_rx || pause_timer_expired;
  endsequence
  property p_idle; !$past(rd_en) |-> rdata == 32'h0; endproperty
  property p_port;
    s_rd |=> rdata[3:2] == {1'b0, $past(second_port)} && rdata[31:8] == 24'h0;
  endproperty
  property p_mode;
    s_rd ##0 has_serializer |=> rdata[5] == $past(interface_mode_select);
  endproperty
  property p_phy_link;
    s_rd ##0 (has_serializer && !interface_mode_select)
      |=> rdata[1] == $past(phy_link);
  endproperty
  property p_ser_link;
    s_rd ##0 (has_serializer && interface_mode_select) |=> rdata[1] ==
      $past(autoneg_enable ? autoneg_link_ok : ctrl_reg[0]);
  endproperty
  property p_plain_link;
    s_rd ##0 !has_serializer |=> rdata[1] == $past(ctrl_reg[0] && phy_link);
  endproperty
  property p_duplex;
    s_rd ##0 ctrl_reg[5] |=> rdata[0] == $past(ctrl_reg[6]);
  endproperty
  property p_speed;
    s_rd ##0 (ctrl_reg[1] && !interface_mode_select)
      |=> rdata[7:6] == $past(ctrl_reg[4:3]);
  endproperty
  property p_unpause; s_clr ##1 s_rd |=> !rdata[4]; endproperty
  property p_mask_off;
    wr_en && addr[7:0] == dsr_pkg::DSR_ADDR_INT_MASK && wdata[2:0] == 3'h0
      |=> !irq;
  endproperty
  a_idle: assert property (p_idle) else $error("rdata not zero");
  a_port: assert property (p_port) else $error("port field");
  a_mode: assert property (p_mode) else $error("mode flag");
  a_phy_link: assert property (p_phy_link) else $error("link");
  a_ser_link: assert property (p_ser_link) else $error("link");
  a_plain_link: assert property (p_plain_link)
    else $error("link");
  a_duplex: assert property (p_duplex) else $error("duplex");
  a_speed: assert property (p_speed) else $error("speed");
  a_unpause: assert property (p_unpause) else $error("paused");
  a_mask_off: assert property (p_mask_off) else $error("irq while masked");
endmodule : dsr_status_properties
bind dsr_status dsr_status_properties #(.ADDR_WIDTH(ADDR_WIDTH))
  i_dsr_status_properties (.*);
`default_nettype wire

// File: verification/test_device_status_readback.sv
// Self-checking bench for the device status readback block.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none
module test_device_status_readback;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic second_port = 1'b0;
  logic has_serializer = 1'b1;
  logic interface_mode_select = 1'b0;
  logic autoneg_enable = 1'b0;
  logic autoneg_link_ok = 1'b0;
  logic autoneg_full_duplex = 1'b0;
  logic phy_link = 1'b0;
  logic [1:0] phy_speed = 2'h0;
  logic [1:0] detected_speed = 2'h0;
  logic symmetric_flow_enable = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [31:0] seed = 32'h1554;
  int ctrl = 0;
  int failures = 0;
  int comparisons = 0;
  dsr_status #(.ADDR_WIDTH(8)) i_dsr_status (.*, .xoff_rx(ev[0]),
    .xon_rx(ev[1]), .pause_timer_expired(ev[2]));
  always #12.5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Expected readback word, pause held clear and auto speed off
  function automatic logic [31:0] model();
    logic [31:0] w;
    w = 32'h0;
    w[0] = ctrl[5] ? ctrl[6] : autoneg_full_duplex;
    if (!has_serializer)
      w[1] = ctrl[0] & phy_link;
    else if (interface_mode_select)
      w[1] = autoneg_enable ? autoneg_link_ok : ctrl[0];
    else
      w[1] = phy_link;
    w[2] = second_port;
    w[5] = interface_mode_select;
    w[7:6] = ctrl[1] ? 2'(ctrl[4:3]) : phy_speed;
    return w;
  endfunction : model
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task automatic pulse(input int k);
    @(posedge clk);
    ev <= 3'h1 << k;
    @(posedge clk);
    ev <= 3'h0;
  endtask : pulse
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("FAIL %0t: watchdog expired", $time);
    results();
  end
  initial
  begin
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] r;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h0C + 8'(i * 4) + (i == 3 ? 8'h28 : 8'h0), d);
      chk(d, 32'h0);
    end
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, d);
    chk(d, model());
    $display("test reset and read-only done");
    for (int i = 0; i < 48; i++)
    begin
      r = rnd();
      @(posedge clk);
      {second_port, has_serializer, interface_mode_select, autoneg_enable,
        autoneg_link_ok, autoneg_full_duplex, phy_link, phy_speed,
        symmetric_flow_enable, detected_speed} <= r[11:0];
      ctrl = int'(r[22:16]) & 32'h7B;
      wr(8'h14, 32'(ctrl));
      m = has_serializer && interface_mode_select ? 32'hFFFFFF3F : '1;
      m[5] = m[5] & has_serializer;
      rd(8'h08, d);
      d = d & m;
      m = model() & m;
      chk(32'(d[0]), 32'(m[0]));
      chk(32'(d[1]), 32'(m[1]));
      chk(32'(d[3:2]), 32'(m[3:2]));
      chk(32'(d[5]), 32'(m[5]));
      chk(d & 32'hFFFFFFD0, m & 32'hFFFFFFD0);
    end
    $display("test random readback done");
    @(posedge clk);
    {has_serializer, interface_mode_select, symmetric_flow_enable} <= 3'h5;
    wr(8'h14, 32'h60);
    wr(8'h0C, 32'h7);
    wr(8'h10, 32'h2);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2)
        wr(8'h14, 32'h20);
      @(posedge clk);
      symmetric_flow_enable <= (i != 3);
      pulse(0);
      rd(8'h08, d);
      chk(32'(d[4]), 32'(i < 2));
      // Read right behind the clear so the unpause check is exercised
      @(posedge clk);
      ev <= 3'h1 << (1 + i % 2);
      @(posedge clk);
      ev <= 3'h0;
      addr <= 8'h08;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
      chk(32'(d[4]), 32'h0);
    end
    chk(32'(irq), 32'h1);
    wr(8'h10, 32'h0);
    chk(32'(irq), 32'h0);
    wr(8'h10, 32'h2);
    chk(32'(irq), 32'h1);
    wr(8'h0C, 32'h7);
    chk(32'(irq), 32'h0);
    rd(8'h10, d);
    chk(d, 32'h2);
    $display("test pause and interrupt done");
    @(posedge clk);
    {interface_mode_select, phy_link, detected_speed} <= 4'h1;
    wr(8'h14, 32'h04);
    rd(8'h08, d);
    chk(32'(d[7:6]), 32'h0);
    @(posedge clk);
    phy_link <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h08, d);
    chk(32'(d[7:6]), 32'h1);
    @(posedge clk);
    detected_speed <= 2'h2;
    repeat (3) @(posedge clk);
    rd(8'h08, d);
    chk(32'(d[7:6]), 32'h1);
    rd(8'h0C, d);
    chk(32'(d[2]), 32'h1);
    $display("test auto speed done");
    results();
  end
endmodule : test_device_status_readback
`default_nettype wire
